// *** pkg/cpu_regset_regs.svh ***
// constants for the cpu register set: reset values, field positions, stack page
`ifndef CPU_REGSET_REGS_SVH
`define CPU_REGSET_REGS_SVH
`define SP_RESET_VAL 6'h3f
`define SP_PAGE_BITS 10'h003
`define SP_LOW_ADDR 16'h00c0
`define SP_HIGH_ADDR 16'h00ff
`define CC_UPPER_ONES 3'h7
`define CC_BIT_C 0
`define CC_BIT_Z 1
`define CC_BIT_N 2
`define CC_BIT_I 3
`define CC_BIT_H 4
`define CALL_PUSH_BYTES 3'h2
`define IRQ_PUSH_BYTES 3'h5
`define INDEX_HIGH_BYTE 8'h00
`endif

// *** pkg/cpu_regset_pkg.sv ***
// types for the cpu register set
package cpu_regset_pkg;
   // flag group of the condition code register
   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } cc_flags_t;
   // kind of alu result being committed
   typedef enum logic [2:0] {
      alu_none  = 3'h0,
      alu_add   = 3'h1,
      alu_logic = 3'h2,
      alu_load  = 3'h3,
      alu_incdec = 3'h4,
      alu_shift = 3'h5,
      alu_btest = 3'h6
   } alu_kind_t;
   // index addressing mode
   typedef enum logic [1:0] {
      idx_none = 2'h0,
      idx_off8 = 2'h1,
      idx_off16 = 2'h2
   } idx_mode_t;
   // alu result bundle
   typedef struct packed {
      alu_kind_t kind;
      logic [7:0] value;
      logic carry;
      logic half;
      logic to_acc;
      logic to_index;
   } alu_result_t;
endpackage

// *** rtl/cpu_register_set_flags.sv ***
// cpu programming-model registers: accumulator, index, stack pointer, pc and flags
//
// Overview of operation
// - stack pointer keeps six live bits; pushing below 0x00c0 wraps to 0x00ff
// - reset and reset-stack instruction load stack pointer with 0x00ff
// - stack pointer points at next free slot; push decrements, pull increments
// - stack address is fixed ten-bit page pattern with six pointer bits below
// - stack has 64 slots; overflow wraps silently and overwrites old bytes
// - subroutine call pushes two bytes, interrupt entry pushes five
// - accumulator is 8 bits and is not changed by reset
// - index register is 8 bits and is not changed by reset
// - indexed without offset: low byte from index, high byte zero
// - indexed with offset: index plus 8- or 16-bit immediate offset
// - program counter is 16 bits, increments per fetch unless loaded
// - five flag bits low, upper three bits read as one
// - reset sets interrupt mask and leaves other flags alone
// - half carry set by carry from bit 3 into bit 4 on add
// - hardware interrupt held pending while mask set, taken once clear
// - interrupt entry sets mask after stacking, before vector fetch
// - return from interrupt restores flags, accumulator and index including the mask; pc and stack pointer are not restored
// - after reset mask is cleared only by clear-mask or wait instruction, or by return from interrupt
// - negative flag equals bit 7 of last result other than a bit test, including loads
// - zero flag set when last result other than a bit test is all zeros
// - carry from bit 7 on arithmetic; shifts and bit tests too; not inc/dec
`include "cpu_regset_regs.svh"
module cpu_register_set_flags
   import cpu_regset_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // sequencer: stack and pc control
   input wire logic i_reset_stack_instr,
   input wire logic i_push,
   input wire logic i_pull,
   input wire logic i_pc_inc,
   input wire logic i_pc_load,
   input wire logic [15:0] i_pc_value,
   // sequencer: alu results and flag instructions
   input wire alu_result_t i_alu,
   input wire logic i_clear_mask_instr,
   input wire logic i_wait_instr,
   input wire logic i_set_mask_instr,
   // interrupt flow
   input wire logic i_irq_req,
   input wire logic i_irq_stacked,
   input wire logic i_return_from_irq_instr,
   input wire logic [4:0] i_pulled_cc,
   input wire logic [7:0] i_pulled_acc,
   input wire logic [7:0] i_pulled_index,
   // index addressing
   input wire idx_mode_t i_idx_mode,
   input wire logic [15:0] i_idx_offset,
   // register views
   output logic [7:0] o_acc,
   output logic [7:0] o_index,
   output logic [15:0] o_stack_addr,
   output logic [15:0] o_pc,
   output logic [7:0] o_cc,
   output logic [15:0] o_idx_addr,
   output logic o_irq_take
);

   logic [5:0] sp;
   logic [5:0] next_sp;
   logic [15:0] next_pc;
   logic [7:0] next_acc;
   logic [7:0] next_index;
   cc_flags_t cc;
   cc_flags_t next_cc;
   logic [15:0] next_idx_addr;
   logic next_irq_take;
   logic irq_pending;
   logic next_irq_pending;

   // stack address from page pattern and pointer
   function automatic logic [15:0] stack_addr(input logic [5:0] p);
      stack_addr = {`SP_PAGE_BITS, p};
   endfunction

   // all-zero test shared by every alu result kind that updates the zero flag
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   // stack pointer and program counter next values
   always_comb begin
      next_sp = sp;
      if (i_reset_stack_instr) begin
         next_sp = `SP_RESET_VAL;
      end else if (i_push && !i_pull) begin
         next_sp = sp - 6'h01;
      end else if (i_pull && !i_push) begin
         next_sp = sp + 6'h01;
      end
      next_pc = o_pc;
      if (i_pc_load) begin
         next_pc = i_pc_value;
      end else if (i_pc_inc) begin
         next_pc = o_pc + 16'h0001;
      end
   end

   // accumulator and index next values
   always_comb begin
      next_acc = o_acc;
      next_index = o_index;
      if (i_return_from_irq_instr) begin
         next_acc = i_pulled_acc;
         next_index = i_pulled_index;
      end else begin
         if (i_alu.to_acc && i_alu.kind != alu_none) begin
            next_acc = i_alu.value;
         end
         if (i_alu.to_index && i_alu.kind != alu_none) begin
            next_index = i_alu.value;
         end
      end
   end

   // condition flags next values
   always_comb begin
      next_cc = cc;
      if (i_return_from_irq_instr) begin
         next_cc = cc_flags_t'(i_pulled_cc);
      end else begin
         if (i_irq_stacked || i_set_mask_instr) begin
            next_cc.i = 1'b1;
         end else if (i_clear_mask_instr || i_wait_instr) begin
            next_cc.i = 1'b0;
         end
         case (i_alu.kind)
            alu_add: begin
               next_cc.h = i_alu.half;
               next_cc.c = i_alu.carry;
               next_cc.n = i_alu.value[7];
               next_cc.z = is_zero(i_alu.value);
            end
            alu_shift, alu_btest: begin
               next_cc.c = i_alu.carry;
               if (i_alu.kind == alu_shift) begin
                  next_cc.n = i_alu.value[7];
                  next_cc.z = is_zero(i_alu.value);
               end
            end
            alu_logic, alu_load, alu_incdec: begin
               next_cc.n = i_alu.value[7];
               next_cc.z = is_zero(i_alu.value);
            end
            default: begin
            end
         endcase
      end
   end

   // interrupt pending latch and take decision
   always_comb begin
      next_irq_pending = irq_pending | i_irq_req;
      if (o_irq_take) begin
         next_irq_pending = i_irq_req;
      end
      next_irq_take = (irq_pending | i_irq_req) && !next_cc.i && !o_irq_take;
   end

   // index address arithmetic
   always_comb begin
      case (i_idx_mode)
         idx_off8: next_idx_addr = {8'h00, next_index} + {8'h00, i_idx_offset[7:0]};
         idx_off16: next_idx_addr = {8'h00, next_index} + i_idx_offset;
         default: next_idx_addr = {`INDEX_HIGH_BYTE, next_index};
      endcase
   end

   // register update; acc, index and four flags are kept across reset
   always_ff @(posedge i_sys_clk) begin
      o_acc <= next_acc;
      o_index <= next_index;
      o_idx_addr <= next_idx_addr;
      cc.h <= next_cc.h;
      cc.n <= next_cc.n;
      cc.z <= next_cc.z;
      cc.c <= next_cc.c;
      o_cc <= {`CC_UPPER_ONES, next_cc};
      if (i_rst) begin
         sp <= `SP_RESET_VAL;
         o_stack_addr <= `SP_HIGH_ADDR;
         o_pc <= 16'h0000;
         cc.i <= 1'b1;
         o_cc <= {`CC_UPPER_ONES, cc.h, 1'b1, cc.n, cc.z, cc.c};
         irq_pending <= 1'b0;
         o_irq_take <= 1'b0;
      end else begin
         sp <= next_sp;
         o_stack_addr <= stack_addr(next_sp);
         o_pc <= next_pc;
         cc.i <= next_cc.i;
         irq_pending <= next_irq_pending;
         o_irq_take <= next_irq_take;
      end
   end

   // checks
   property p_sp_push;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_push && !i_pull && !i_reset_stack_instr) |=> (sp == $past(sp) - 6'h01);
   endproperty
   a_sp_push: assert property (p_sp_push) else $error("push did not decrement");
   property p_sp_wrap;
      @(posedge i_sys_clk) disable iff (i_rst)
      (sp == 6'h00 && i_push && !i_pull && !i_reset_stack_instr) |=> (o_stack_addr == `SP_HIGH_ADDR);
   endproperty
   a_sp_wrap: assert property (p_sp_wrap) else $error("stack did not wrap");
   property p_rsp;
      @(posedge i_sys_clk) i_reset_stack_instr |=> (o_stack_addr == `SP_HIGH_ADDR);
   endproperty
   a_rsp: assert property (p_rsp) else $error("reset stack failed");
   property p_range;
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_stack_addr >= `SP_LOW_ADDR) && (o_stack_addr <= `SP_HIGH_ADDR);
   endproperty
   a_range: assert property (p_range) else $error("stack address outside page");
   property p_upper;
      @(posedge i_sys_clk) disable iff (i_rst)
      o_cc[7:5] == `CC_UPPER_ONES;
   endproperty
   a_upper: assert property (p_upper) else $error("upper flag bits not ones");
   property p_rst_mask;
      @(posedge i_sys_clk) i_rst |=> o_cc[`CC_BIT_I];
   endproperty
   a_rst_mask: assert property (p_rst_mask) else $error("reset did not set the mask");
   // the four result flags held at reset entry must come through it unchanged
   property p_rst_keep;
      @(posedge i_sys_clk) (i_rst && !$past(i_rst))
      |=> ({o_cc[`CC_BIT_H], o_cc[`CC_BIT_N], o_cc[`CC_BIT_Z], o_cc[`CC_BIT_C]} == $past({cc.h, cc.n, cc.z, cc.c}));
   endproperty
   a_rst_keep: assert property (p_rst_keep) else $error("reset changed a result flag");
   property p_mask_hold;
      @(posedge i_sys_clk) disable iff (i_rst)
      (cc.i && !i_clear_mask_instr && !i_wait_instr && !i_return_from_irq_instr) |=> cc.i;
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask cleared illegally");
   property p_no_take_masked;
      @(posedge i_sys_clk) disable iff (i_rst) o_irq_take |-> !cc.i;
   endproperty
   a_no_take_masked: assert property (p_no_take_masked) else $error("irq taken while masked");
   property p_stacked_mask;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_irq_stacked && !i_return_from_irq_instr) |=> o_cc[`CC_BIT_I];
   endproperty
   a_stacked_mask: assert property (p_stacked_mask) else $error("mask not set at entry");
   property p_zero;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_alu.kind == alu_load && !i_return_from_irq_instr) |=> (o_cc[`CC_BIT_Z] == ($past(i_alu.value) == 8'h00));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   // flag updates committed by the sequencer
   property p_half;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_alu.kind == alu_add && !i_return_from_irq_instr) |=> (o_cc[`CC_BIT_H] == $past(i_alu.half));
   endproperty
   a_half: assert property (p_half) else $error("half carry flag wrong");
   property p_neg;
      @(posedge i_sys_clk) disable iff (i_rst)
      ((i_alu.kind inside {alu_add, alu_logic, alu_load}) && !i_return_from_irq_instr)
      |=> (o_cc[`CC_BIT_N] == $past(i_alu.value[7]));
   endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong");
   property p_incdec_carry;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_alu.kind == alu_incdec && !i_return_from_irq_instr) |=> (o_cc[`CC_BIT_C] == $past(cc.c));
   endproperty
   a_incdec_carry: assert property (p_incdec_carry) else $error("inc or dec touched carry");

   // return from interrupt restores flags, accumulator and index together
   property p_rti;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_return_from_irq_instr |=> (o_cc[4:0] == $past(i_pulled_cc)) && (o_acc == $past(i_pulled_acc))
         && (o_index == $past(i_pulled_index));
   endproperty
   a_rti: assert property (p_rti) else $error("return did not restore registers");

   // stack frames: a call moves the pointer down two, an interrupt entry five
   property p_call_frame;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_push && !i_pull && !i_reset_stack_instr)[*2] |=> (sp == $past(sp, 2) - {3'h0, `CALL_PUSH_BYTES});
   endproperty
   a_call_frame: assert property (p_call_frame) else $error("call frame depth wrong");
   property p_irq_frame;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_push && !i_pull && !i_reset_stack_instr)[*5] |=> (sp == $past(sp, 5) - {3'h0, `IRQ_PUSH_BYTES});
   endproperty
   a_irq_frame: assert property (p_irq_frame) else $error("interrupt frame depth wrong");

   // program counter step and plain indexed address
   property p_pc_step;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_pc_inc && !i_pc_load) |=> (o_pc == $past(o_pc) + 16'h0001);
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step by one");
   property p_idx_plain;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_idx_mode == idx_none) |=> (o_idx_addr == {`INDEX_HIGH_BYTE, o_index});
   endproperty
   a_idx_plain: assert property (p_idx_plain) else $error("plain indexed address wrong");

   // main scenarios worth seeing at least once
   c_wrap: cover property (@(posedge i_sys_clk) sp == 6'h00 ##1 sp == 6'h3f);
   c_take: cover property (@(posedge i_sys_clk) o_irq_take);
   c_rti: cover property (@(posedge i_sys_clk) i_return_from_irq_instr);
   c_irq_frame: cover property (@(posedge i_sys_clk) disable iff (i_rst) (i_push && !i_pull)[*5]);
endmodule

// *** testbench/tb_top.sv ***
// self-checking testbench for the cpu register set
module tb_top
   import cpu_regset_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // stimulus and observed outputs
   logic i_sys_clk, i_rst, i_reset_stack_instr, i_push, i_pull, i_pc_inc, i_pc_load, i_clear_mask_instr;
   logic i_wait_instr, i_set_mask_instr, i_irq_req, i_irq_stacked, i_return_from_irq_instr, o_irq_take;
   logic [15:0] i_pc_value, i_idx_offset, o_stack_addr, o_pc, o_idx_addr;
   logic [7:0] i_pulled_acc, i_pulled_index, o_acc, o_index, o_cc;
   logic [4:0] i_pulled_cc;
   alu_result_t i_alu;
   idx_mode_t i_idx_mode;
   int num_errors = 0;
   int samples_checked = 0;

   cpu_register_set_flags DUT (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_stack_instr(i_reset_stack_instr), .i_push(i_push),
      .i_pull(i_pull), .i_pc_inc(i_pc_inc), .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_alu(i_alu),
      .i_clear_mask_instr(i_clear_mask_instr), .i_wait_instr(i_wait_instr), .i_set_mask_instr(i_set_mask_instr),
      .i_irq_req(i_irq_req), .i_irq_stacked(i_irq_stacked), .i_return_from_irq_instr(i_return_from_irq_instr),
      .i_pulled_cc(i_pulled_cc), .i_pulled_acc(i_pulled_acc), .i_pulled_index(i_pulled_index),
      .i_idx_mode(i_idx_mode), .i_idx_offset(i_idx_offset), .o_acc(o_acc), .o_index(o_index),
      .o_stack_addr(o_stack_addr), .o_pc(o_pc), .o_cc(o_cc), .o_idx_addr(o_idx_addr), .o_irq_take(o_irq_take)
   );

   // 50 MHz clock
   initial i_sys_clk = 1'b0;
   always #10 i_sys_clk = ~i_sys_clk;

   // verdict and end of run
   task automatic report_and_stop();
      $display("mismatches %0d of %0d checks", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // compare one value, count and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   // drop every request strobe
   task automatic rest();
      {i_reset_stack_instr, i_push, i_pull, i_pc_inc, i_pc_load, i_clear_mask_instr} = '0;
      {i_wait_instr, i_set_mask_instr, i_irq_req, i_irq_stacked, i_return_from_irq_instr} = '0;
      i_alu = '0;
      i_idx_mode = idx_none;
   endtask

   // commit one alu result
   task automatic op(alu_kind_t k, logic [7:0] v, logic c, logic h, logic ta, logic tx);
      i_alu = '{k, v, c, h, ta, tx};
      tick(1);
   endtask

   task automatic flg(alu_kind_t k, logic [7:0] v, logic c, logic h, logic [7:0] e);
      op(k, v, c, h, 1'b1, 1'b0);
      check(16'(o_cc), {8'h00, e});
   endtask

   // reset values, then a mid-run reset that must keep acc, index and the four result flags
   task automatic t_reset_keep();
      check(o_stack_addr, 16'h00ff);
      check(16'({o_cc[7:5], o_cc[3]}), 16'h000f);
      check(o_pc, 16'h0000);
      i_clear_mask_instr = 1'b1;
      i_push = 1'b1;
      tick(1);
      check(16'(o_cc[3]), 16'h0000);
      op(alu_load, 8'ha5, 1'b0, 1'b0, 1'b0, 1'b1);
      op(alu_add, 8'h80, 1'b1, 1'b1, 1'b1, 1'b0);
      check(16'(o_cc), 16'h00f5);
      check(o_stack_addr, 16'h00fc);
      rest();
      i_rst = 1'b1;
      tick(1);
      i_rst = 1'b0;
      check(16'(o_acc), 16'h0080);
      check(16'(o_index), 16'h00a5);
      check(16'(o_cc), 16'h00fd);
      check(o_stack_addr, 16'h00ff);
   endtask

   // which flags each kind of result touches
   task automatic t_flags();
      flg(alu_add, 8'h00, 1'b1, 1'b0, 8'heb);
      flg(alu_incdec, 8'hff, 1'b0, 1'b1, 8'hed);
      flg(alu_shift, 8'h00, 1'b0, 1'b1, 8'hea);
      flg(alu_btest, 8'h80, 1'b1, 1'b1, 8'heb);
      flg(alu_logic, 8'h80, 1'b0, 1'b1, 8'hed);
      flg(alu_load, 8'h00, 1'b0, 1'b1, 8'heb);
      flg(alu_add, 8'h7f, 1'b0, 1'b1, 8'hf8);
      check(16'(o_acc), 16'h007f);
      rest();
      tick(1);
   endtask

   // 65 pushes wrap the page, then push with pull, pulls and reset-stack
   task automatic t_stack();
      logic [5:0] sp;
      sp = 6'h3f;
      i_push = 1'b1;
      for (int k = 0; k < 65; k++) begin
         tick(1);
         sp = sp - 6'h01;
         check(o_stack_addr, {10'h003, sp});
      end
      i_pull = 1'b1;
      tick(1);
      check(o_stack_addr, {10'h003, sp});
      i_push = 1'b0;
      repeat (2) begin
         tick(1);
         sp = sp + 6'h01;
         check(o_stack_addr, {10'h003, sp});
      end
      i_pull = 1'b0;
      i_reset_stack_instr = 1'b1;
      tick(1);
      check(o_stack_addr, 16'h00ff);
      rest();
      tick(1);
   endtask

   // load, increment, load over increment, 16-bit wrap
   task automatic t_pc();
      i_pc_load = 1'b1;
      i_pc_value = 16'h1234;
      tick(1);
      check(o_pc, 16'h1234);
      i_pc_load = 1'b0;
      i_pc_inc = 1'b1;
      tick(3);
      check(o_pc, 16'h1237);
      i_pc_load = 1'b1;
      i_pc_value = 16'hfffe;
      tick(1);
      check(o_pc, 16'hfffe);
      i_pc_load = 1'b0;
      tick(2);
      check(o_pc, 16'h0000);
      rest();
      tick(1);
   endtask

   // indexed addresses with carry past the low byte
   task automatic t_index();
      op(alu_load, 8'hf0, 1'b0, 1'b0, 1'b0, 1'b1);
      check(o_idx_addr, 16'h00f0);
      check(16'(o_index), 16'h00f0);
      i_idx_mode = idx_off8;
      i_idx_offset = 16'h0020;
      tick(1);
      check(o_idx_addr, 16'h0110);
      i_idx_mode = idx_off16;
      i_idx_offset = 16'h1ff0;
      tick(1);
      check(o_idx_addr, 16'h20e0);
      rest();
      tick(1);
   endtask

   // masked request held, taken once, entry, return and mask instructions
   task automatic t_irq();
      logic [15:0] hits;
      hits = 16'h0000;
      i_irq_req = 1'b1;
      tick(1);
      i_irq_req = 1'b0;
      repeat (3) begin
         tick(1);
         hits = hits + 16'(o_irq_take);
      end
      check(hits, 16'h0000);
      i_clear_mask_instr = 1'b1;
      tick(1);
      i_clear_mask_instr = 1'b0;
      repeat (4) begin
         hits = hits + 16'(o_irq_take);
         tick(1);
      end
      check(hits, 16'h0001);
      i_irq_stacked = 1'b1;
      tick(1);
      check(16'(o_cc[3]), 16'h0001);
      i_irq_stacked = 1'b0;
      i_return_from_irq_instr = 1'b1;
      i_pulled_cc = 5'h15;
      i_pulled_acc = 8'h3c;
      i_pulled_index = 8'hc3;
      tick(1);
      check(16'(o_cc), 16'h00f5);
      check({o_acc, o_index}, 16'h3cc3);
      i_return_from_irq_instr = 1'b0;
      i_set_mask_instr = 1'b1;
      i_clear_mask_instr = 1'b1;
      tick(1);
      check(16'(o_cc[3]), 16'h0001);
      {i_set_mask_instr, i_clear_mask_instr, i_wait_instr} = 3'h1;
      tick(1);
      check(16'(o_cc[3]), 16'h0000);
      rest();
      tick(1);
   endtask

   // guard against a hang
   initial begin
      #1ms;
      num_errors++;
      report_and_stop();
   end

   // main sequence
   initial begin
      rest();
      {i_pc_value, i_idx_offset, i_pulled_cc, i_pulled_acc, i_pulled_index} = '0;
      i_rst = 1'b1;
      tick(12);
      i_rst = 1'b0;
      t_reset_keep();
      t_flags();
      t_stack();
      t_pc();
      t_index();
      t_irq();
      report_and_stop();
   end
endmodule
